/* File: hdl/cbi_pkg.sv */
package cbi_pkg;

  // ****************************************************************
  // machine cycle kinds and T states
  // ****************************************************************
  typedef enum logic [1:0] {
    KIND_FETCH,
    KIND_READ,
    KIND_WRITE,
    KIND_INT_ACK
  } cbi_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_TW,
    ST_T3,
    ST_T4,
    ST_T5,
    ST_T6
  } cbi_state_e;

  // ****************************************************************
  // fixed values
  // ****************************************************************
  localparam logic [15:0] NMI_RESTART_ADDR   = 16'h0066;
  localparam logic [1:0]  INT_ACK_AUTO_WAITS = 2'h2;
  localparam logic [1:0]  MAX_EXTRA_STATES   = 2'h2;
  localparam int          REFRESH_BITS       = 7;
  localparam logic [6:0]  REFRESH_RST        = 7'h00;
  localparam logic [15:0] ADDR_RST           = 16'h0000;
  localparam logic [7:0]  DATA_RST           = 8'h00;
  localparam logic [2:0]  SYNC_RST           = 3'h7;
  // clocks per T state: one high half and one low half
  localparam int          CLK_PER_T          = 2;
  localparam logic [4:0]  FETCH_CLKS_MIN     = 5'h08;
  localparam logic [4:0]  DATA_CLKS_MIN      = 5'h06;

endpackage

/* File: hdl/cbi_irq_flags.sv */
module cbi_irq_flags (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic enable_irq_instr,
  input  wire logic disable_irq_instr,
  input  wire logic return_from_nonmaskable,
  input  wire logic return_from_maskable,
  input  wire logic load_acc_from_page_reg,
  input  wire logic load_acc_from_refresh_ctr,
  input  wire logic int_accept,
  input  wire logic nmi_accept,
  output logic      irq_enable_live,
  output logic      irq_enable_saved,
  output logic      parity_flag
);
  import cbi_pkg::*;

  typedef struct packed {
    logic live;
    logic saved;
    logic pv;
  } cbi_flags_s;

  cbi_flags_s r_r;
  cbi_flags_s r_nxt;

  // next value of both enable flip-flops
  always_comb begin
    r_nxt = r_r;
    if (load_acc_from_page_reg || load_acc_from_refresh_ctr) begin
      r_nxt.pv = r_r.saved;
    end
    if (int_accept) begin
      r_nxt.live  = 1'b0;
      r_nxt.saved = 1'b0;
    end else if (nmi_accept) begin
      r_nxt.saved = r_r.live;
      r_nxt.live  = 1'b0;
    end else if (disable_irq_instr) begin
      r_nxt.live  = 1'b0;
      r_nxt.saved = 1'b0;
    end else if (enable_irq_instr) begin
      r_nxt.live  = 1'b1;
      r_nxt.saved = 1'b1;
    end else if (return_from_nonmaskable) begin
      r_nxt.live = r_r.saved;
    end
    if (return_from_maskable) begin
      r_nxt.live = r_nxt.live;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign irq_enable_live  = r_r.live;
  assign irq_enable_saved = r_r.saved;
  assign parity_flag      = r_r.pv;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  nmi_save_a: assert property (nmi_accept && !int_accept |=> !irq_enable_live && irq_enable_saved == $past(irq_enable_live))
    else $error("nmi accept did not save the live flag");
  return_from_nonmaskable_restore_a: assert property (return_from_nonmaskable && !int_accept && !nmi_accept && !disable_irq_instr && !enable_irq_instr |=> irq_enable_live == $past(irq_enable_saved))
    else $error("return from nmi did not restore live flag");
  di_clear_a: assert property (disable_irq_instr |=> !irq_enable_live && !irq_enable_saved)
    else $error("disable left a flag set");
  return_from_maskable_keep_a: assert property (return_from_maskable && !int_accept && !nmi_accept && !disable_irq_instr && !enable_irq_instr && !return_from_nonmaskable |=> $stable(irq_enable_live) && $stable(irq_enable_saved))
    else $error("maskable return changed a flag");
  pv_copy_a: assert property (load_acc_from_page_reg |=> parity_flag == $past(irq_enable_saved))
    else $error("parity flag not loaded from saved flag");
endmodule

/* File: hdl/cbi_bus_seq.sv */
module cbi_bus_seq (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              cycle_start,
  input  wire cbi_pkg::cbi_kind_e cycle_kind,
  input  wire logic [1:0]        extra_states,
  input  wire logic [15:0]       cycle_addr,
  input  wire logic [7:0]        write_data,
  input  wire logic [7:0]        page_reg,
  input  wire logic              instr_done,
  input  wire logic              enable_irq_instr,
  input  wire logic              disable_irq_instr,
  input  wire logic              return_from_nonmaskable,
  input  wire logic              return_from_maskable,
  input  wire logic              load_acc_from_page_reg,
  input  wire logic              load_acc_from_refresh_ctr,
  input  wire logic              int_req_n,
  input  wire logic              nmi_req_n,
  input  wire logic              wait_n,
  input  wire logic [7:0]        data_in,
  output logic [15:0]            address_bus,
  output logic [7:0]             data_out,
  output logic                   data_oe_n,
  output logic                   memory_request_n,
  output logic                   io_request_n,
  output logic                   read_n,
  output logic                   write_n,
  output logic                   refresh_strobe_n,
  output logic                   opcode_fetch_n,
  output logic [7:0]             read_data,
  output logic                   read_valid,
  output logic                   cycle_done,
  output logic                   cycle_busy,
  output logic [15:0]            service_addr,
  output logic                   service_load,
  output logic                   nmi_taken,
  output logic                   int_taken,
  output logic                   irq_enable_live,
  output logic                   irq_enable_saved,
  output logic                   parity_flag
);
  import cbi_pkg::*;

  typedef struct packed {
    cbi_state_e        st;
    logic              ph;
    cbi_kind_e         kind;
    logic [1:0]        extra;
    logic [1:0]        autow;
    logic              wt;
    logic [15:0]       addr;
    logic [7:0]        dout;
    logic              oe_n;
    logic              memory_request_n_n;
    logic              io_request_n_n;
    logic              rd_n;
    logic              wr_n;
    logic              refresh_strobe_n_n;
    logic              m1_n;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              done;
    logic              busy;
    logic [REFRESH_BITS-1:0] rfc;
    logic [1:0]        vstep;
    logic [15:0]       table_addr;
    logic [15:0]       svc_addr;
    logic              svc_load;
    logic              nmi_acc;
    logic              int_acc;
    logic              nmi_latch;
    logic              ei_pend;
    logic [2:0]        int_s;
    logic [2:0]        nmi_s;
    logic [2:0]        wait_s;
    logic              int_f;
    logic              nmi_f;
    logic              nmi_fd;
    logic              wait_f;
  } cbi_seq_s;

  cbi_seq_s   r_r;
  cbi_seq_s   r_nxt;
  logic       take;
  logic       nmi_fall;
  logic       go;
  cbi_kind_e  go_kind;
  logic [15:0] go_addr;
  logic [1:0] go_extra;

  // enable flip-flops live in their own unit
  cbi_irq_flags u_flags (
    .clock                     (clock),
    .srst                      (srst),
    .enable_irq_instr          (enable_irq_instr),
    .disable_irq_instr         (disable_irq_instr),
    .return_from_nonmaskable   (return_from_nonmaskable),
    .return_from_maskable      (return_from_maskable),
    .load_acc_from_page_reg    (load_acc_from_page_reg),
    .load_acc_from_refresh_ctr (load_acc_from_refresh_ctr),
    .int_accept                (r_r.int_acc),
    .nmi_accept                (r_r.nmi_acc),
    .irq_enable_live           (irq_enable_live),
    .irq_enable_saved          (irq_enable_saved),
    .parity_flag               (parity_flag)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    r_nxt          = r_r;
    r_nxt.rvalid   = 1'b0;
    r_nxt.done     = 1'b0;
    r_nxt.svc_load = 1'b0;
    r_nxt.nmi_acc  = 1'b0;
    r_nxt.int_acc  = 1'b0;
    go             = 1'b0;
    go_kind        = cycle_kind;
    go_addr        = cycle_addr;
    go_extra       = (extra_states > MAX_EXTRA_STATES) ? MAX_EXTRA_STATES : extra_states;

    // pin synchronisers, level counts once stages two and three agree
    r_nxt.int_s  = {r_r.int_s[1:0], int_req_n};
    r_nxt.nmi_s  = {r_r.nmi_s[1:0], nmi_req_n};
    r_nxt.wait_s = {r_r.wait_s[1:0], wait_n};
    if (r_r.int_s[1] == r_r.int_s[2]) r_nxt.int_f = r_r.int_s[2];
    if (r_r.nmi_s[1] == r_r.nmi_s[2]) r_nxt.nmi_f = r_r.nmi_s[2];
    if (r_r.wait_s[1] == r_r.wait_s[2]) r_nxt.wait_f = r_r.wait_s[2];
    r_nxt.nmi_fd = r_r.nmi_f;
    nmi_fall     = r_r.nmi_fd && !r_r.nmi_f;

    // hold off maskable for one instruction
    if (enable_irq_instr) begin
      r_nxt.ei_pend = 1'b1;
    end else if (instr_done) begin
      r_nxt.ei_pend = 1'b0;
    end

    // interrupt decision only at an instruction boundary with the bus idle
    take = instr_done && (r_r.st == ST_IDLE) && (r_r.vstep == 2'h0)
           && !r_r.nmi_acc && !r_r.int_acc;
    if (nmi_fall) r_nxt.nmi_latch = 1'b1;
    if (take && r_r.nmi_latch) begin
      r_nxt.nmi_acc   = 1'b1;
      r_nxt.nmi_latch = nmi_fall; // new edge wins over clear
      r_nxt.svc_addr  = NMI_RESTART_ADDR;
      r_nxt.svc_load  = 1'b1;
    end else if (take && !r_r.int_f && irq_enable_live && !r_r.ei_pend && !enable_irq_instr) begin
      r_nxt.int_acc = 1'b1;
      go            = 1'b1;
      go_kind       = KIND_INT_ACK;
      go_addr       = cycle_addr;
      go_extra      = 2'h0;
    // two table bytes in a row
    end else if (r_r.st == ST_IDLE && r_r.vstep != 2'h0 && !r_r.done) begin
      go       = 1'b1;
      go_kind  = KIND_READ;
      go_addr  = (r_r.vstep == 2'h2) ? r_r.table_addr + 16'h0001 : r_r.table_addr;
      go_extra = 2'h0;
    end else if (r_r.st == ST_IDLE && r_r.vstep == 2'h0 && cycle_start) begin
      go = 1'b1;
    end

    if (r_r.st != ST_IDLE) r_nxt.ph = !r_r.ph;

    case (r_r.st)
      ST_IDLE: begin
        if (go) begin
          // address and fetch marker at cycle start
          r_nxt.st    = ST_T1;
          r_nxt.ph    = 1'b0;
          r_nxt.kind  = go_kind;
          r_nxt.extra = go_extra;
          r_nxt.addr  = go_addr;
          r_nxt.m1_n  = !(go_kind == KIND_FETCH || go_kind == KIND_INT_ACK);
          r_nxt.dout  = write_data;
          r_nxt.oe_n  = (go_kind != KIND_WRITE);
        end
      end
      ST_T1: begin
        if (!r_r.ph) begin
          // strobes half a state after address
          if (r_r.kind != KIND_INT_ACK) r_nxt.memory_request_n_n = 1'b0;
          if (r_r.kind == KIND_FETCH || r_r.kind == KIND_READ) r_nxt.rd_n = 1'b0;
        end else begin
          r_nxt.st = ST_T2;
          // write strobe once data has settled
          if (r_r.kind == KIND_WRITE) r_nxt.wr_n = 1'b0;
          r_nxt.autow = (r_r.kind == KIND_INT_ACK) ? INT_ACK_AUTO_WAITS : 2'h0;
        end
      end
      ST_T2, ST_TW: begin
        if (!r_r.ph) begin
          r_nxt.wt = (r_r.autow != 2'h0) || !r_r.wait_f;
        end else if (r_r.wt) begin
          r_nxt.st = ST_TW;
          if (r_r.autow != 2'h0) r_nxt.autow = r_r.autow - 2'h1;
          // io request instead of memory request
          if (r_r.kind == KIND_INT_ACK) r_nxt.io_request_n_n = 1'b0;
        end else begin
          r_nxt.st = ST_T3;
          if (r_r.kind == KIND_FETCH || r_r.kind == KIND_INT_ACK) begin
            // capture at T3 edge, drop strobes
            r_nxt.rdata  = data_in;
            r_nxt.rvalid = 1'b1;
            r_nxt.memory_request_n_n = 1'b1;
            r_nxt.rd_n   = 1'b1;
            r_nxt.io_request_n_n = 1'b1;
            r_nxt.m1_n   = 1'b1;
            r_nxt.addr   = {page_reg, 1'b0, r_r.rfc};
            r_nxt.refresh_strobe_n_n = 1'b0;
          end
        end
      end
      ST_T3: begin
        if (!r_r.ph) begin
          if (r_r.kind == KIND_FETCH || r_r.kind == KIND_INT_ACK) begin
            r_nxt.memory_request_n_n = 1'b0;
          end else begin
            if (r_r.kind == KIND_READ) begin
              r_nxt.rdata  = data_in;
              r_nxt.rvalid = 1'b1;
            end
            r_nxt.memory_request_n_n = 1'b1;
            r_nxt.rd_n   = 1'b1;
            r_nxt.wr_n   = 1'b1;
          end
        end else if (r_r.kind == KIND_FETCH || r_r.kind == KIND_INT_ACK) begin
          r_nxt.st = ST_T4;
        end else if (r_r.extra != 2'h0) begin
          r_nxt.st    = ST_T4;
          r_nxt.extra = r_r.extra - 2'h1;
        end else begin
          r_nxt.st = ST_IDLE;
        end
      end
      ST_T4, ST_T5, ST_T6: begin
        if (!r_r.ph) begin
          if (r_r.st == ST_T4) r_nxt.memory_request_n_n = 1'b1;
        end else begin
          if (r_r.st == ST_T4 && !r_r.refresh_strobe_n_n) begin
            r_nxt.refresh_strobe_n_n = 1'b1;
            r_nxt.rfc = r_r.rfc + 7'h01;
          end
          if (r_r.extra != 2'h0 && r_r.st != ST_T6) begin
            r_nxt.st    = (r_r.st == ST_T4) ? ST_T5 : ST_T6;
            r_nxt.extra = r_r.extra - 2'h1;
          end else begin
            r_nxt.st = ST_IDLE;
          end
        end
      end
      default: r_nxt.st = ST_IDLE;
    endcase

    // end of a machine cycle and vector bookkeeping
    if (r_r.st != ST_IDLE && r_nxt.st == ST_IDLE) begin
      r_nxt.done = 1'b1;
      r_nxt.oe_n = 1'b1;
      if (r_r.kind == KIND_INT_ACK) begin
        // peripheral vector is the low byte
        r_nxt.table_addr = {page_reg, r_r.rdata};
        r_nxt.vstep      = 2'h1;
      end else if (r_r.kind == KIND_READ && r_r.vstep == 2'h1) begin
        r_nxt.svc_addr[7:0] = r_r.rdata;
        r_nxt.vstep         = 2'h2;
      end else if (r_r.kind == KIND_READ && r_r.vstep == 2'h2) begin
        r_nxt.svc_addr[15:8] = r_r.rdata;
        r_nxt.svc_load       = 1'b1;
        r_nxt.vstep          = 2'h0;
      end
    end
    r_nxt.busy = (r_nxt.st != ST_IDLE) || (r_nxt.vstep != 2'h0);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      r_r        <= '0;
      r_r.st     <= ST_IDLE;
      r_r.kind   <= KIND_FETCH;
      r_r.addr   <= ADDR_RST;
      r_r.dout   <= DATA_RST;
      r_r.rfc    <= REFRESH_RST;
      r_r.oe_n   <= 1'b1;
      r_r.memory_request_n_n <= 1'b1;
      r_r.io_request_n_n <= 1'b1;
      r_r.rd_n   <= 1'b1;
      r_r.wr_n   <= 1'b1;
      r_r.refresh_strobe_n_n <= 1'b1;
      r_r.m1_n   <= 1'b1;
      r_r.int_s  <= SYNC_RST;
      r_r.nmi_s  <= SYNC_RST;
      r_r.wait_s <= SYNC_RST;
      r_r.int_f  <= 1'b1;
      r_r.nmi_f  <= 1'b1;
      r_r.nmi_fd <= 1'b1;
      r_r.wait_f <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from the state register
  assign address_bus      = r_r.addr;
  assign data_out         = r_r.dout;
  assign data_oe_n        = r_r.oe_n;
  assign memory_request_n = r_r.memory_request_n_n;
  assign io_request_n     = r_r.io_request_n_n;
  assign read_n           = r_r.rd_n;
  assign write_n          = r_r.wr_n;
  assign refresh_strobe_n = r_r.refresh_strobe_n_n;
  assign opcode_fetch_n   = r_r.m1_n;
  assign read_data        = r_r.rdata;
  assign read_valid       = r_r.rvalid;
  assign cycle_done       = r_r.done;
  assign cycle_busy       = r_r.busy;
  assign service_addr     = r_r.svc_addr;
  assign service_load     = r_r.svc_load;
  assign nmi_taken        = r_r.nmi_acc;
  assign int_taken        = r_r.int_acc;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [4:0] len_r;
  logic       waited_r;

  // cycle length helper for the checks
  always_ff @(posedge clock) begin
    if (srst || r_r.st == ST_IDLE) begin
      len_r    <= 5'h00;
      waited_r <= 1'b0;
    end else begin
      len_r    <= len_r + 5'h01;
      waited_r <= waited_r || (r_r.st == ST_TW) || (r_r.extra != 2'h0);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  nmi_restart_a: assert property (nmi_taken |-> service_load && service_addr == 16'h0066)
    else $error("nmi did not load restart address");
  int_live_a: assert property (int_taken |-> $past(irq_enable_live) && !$past(r_r.ei_pend))
    else $error("maskable accepted while disabled");
  ei_hold_a: assert property (enable_irq_instr && instr_done |=> !int_taken)
    else $error("maskable accepted right after enable");
  strobe_half_a: assert property (r_r.st == ST_T1 && !r_r.ph && r_r.kind == KIND_FETCH |=> !memory_request_n && !read_n && !opcode_fetch_n)
    else $error("fetch strobes not half a state after address");
  refresh_capture_a: assert property ($fell(refresh_strobe_n) |-> read_valid && read_n && address_bus[6:0] == $past(r_r.rfc))
    else $error("refresh start without capture");
  refresh_rd_a: assert property (!refresh_strobe_n |-> read_n)
    else $error("read strobe during refresh");
  ack_waits_a: assert property ($fell(io_request_n) |-> !io_request_n [*4])
    else $error("acknowledge shorter than two waits");
  write_data_a: assert property (!write_n |-> !data_oe_n && !memory_request_n && data_out == $past(data_out))
    else $error("write strobe without stable data");
  data_len_a: assert property (cycle_done && !waited_r && r_r.kind != KIND_FETCH && r_r.kind != KIND_INT_ACK |-> len_r == DATA_CLKS_MIN)
    else $error("plain data cycle not three states");
  fetch_len_a: assert property (cycle_done && !waited_r && r_r.kind == KIND_FETCH |-> len_r == FETCH_CLKS_MIN)
    else $error("plain fetch not four states");

  ack_cycle_c: cover property (int_taken ##[1:40] service_load);
  nmi_take_c: cover property (nmi_taken);
  wait_fetch_c: cover property (r_r.st == ST_TW && r_r.kind == KIND_FETCH);
endmodule

/* File: dv/cbi_mem_model.sv */
module cbi_mem_model (
  input  wire logic        clock,
  input  wire logic [15:0] address_bus,
  input  wire logic [7:0]  data_out,
  input  wire logic        memory_request_n,
  input  wire logic        io_request_n,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic        opcode_fetch_n,
  input  wire logic        stall,
  input  wire logic        raise_irq,
  input  wire logic        chain_enable_in,
  output logic [7:0]       data_in,
  output logic             wait_n,
  output logic             int_req_n,
  output logic             chain_enable_out,
  output logic [7:0]       last_write
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // memory and one chained peripheral
  // ****************************************************************
  localparam logic [7:0] VECTOR = 8'h40;
  logic       pending_r = 1'b0;
  logic [7:0] prev_r    = 8'h00;
  logic [3:0] held_r    = 4'h0;
  // vector bit0 clear
  // memory data, vector, or inverse of last value when released
  always_comb begin
    if (!memory_request_n && !read_n)
      data_in = address_bus[7:0] + address_bus[15:8];
    else if (!io_request_n && !opcode_fetch_n)
      data_in = VECTOR;
    else
      data_in = ~prev_r;
  end
  assign chain_enable_out = chain_enable_in & ~pending_r;
  assign int_req_n        = ~pending_r;
  // slow memory: wait for six clocks of each strobe
  assign wait_n           = ~(stall && held_r < 4'h6);
  // request latch, bus history and strobe age
  always_ff @(posedge clock) begin
    prev_r <= data_in;
    held_r <= memory_request_n ? 4'h0 : held_r + 4'h1;
    if (raise_irq)
      pending_r <= 1'b1;
    else if (!io_request_n && !opcode_fetch_n)
      pending_r <= 1'b0;
  end
  // write data taken as the strobe ends
  always_ff @(posedge write_n)
    last_write <= data_out;
endmodule

/* File: dv/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cbi_pkg::*;
  // ****************************************************************
  // bench
  // ****************************************************************
  typedef struct packed {
    cbi_kind_e  kind;
    logic [1:0] extra;
    logic [4:0] clks;
  } cbi_row_s;
  cbi_row_s rows [8] = '{
    '{KIND_FETCH, 2'h0, 5'h08}, '{KIND_FETCH, 2'h1, 5'h0A}, '{KIND_FETCH, 2'h2, 5'h0C},
    '{KIND_READ, 2'h0, 5'h06}, '{KIND_READ, 2'h2, 5'h0A}, '{KIND_WRITE, 2'h0, 5'h06},
    '{KIND_WRITE, 2'h1, 5'h08}, '{KIND_READ, 2'h0, 5'h00}};
  logic        clock, srst, cycle_start, instr_done, int_req_n, nmi_req_n, wait_n;
  logic        enable_irq_instr, disable_irq_instr, return_from_nonmaskable;
  logic        return_from_maskable, load_acc_from_page_reg, load_acc_from_refresh_ctr;
  logic        stall, raise_irq, data_oe_n, memory_request_n, io_request_n, read_n;
  logic        write_n, refresh_strobe_n, opcode_fetch_n, read_valid, cycle_done;
  logic        cycle_busy, service_load, nmi_taken, int_taken, irq_enable_live;
  logic        irq_enable_saved, parity_flag, chain_enable_out, saw_refresh_strobe_n, clash, saw_io, got;
  logic        chain_enable_in = 1'b1;
  cbi_kind_e   cycle_kind;
  logic [1:0]  extra_states;
  logic [6:0]  rf, prev_rf;
  logic [7:0]  write_data, page_reg, data_in, data_out, read_data, last_write;
  logic [15:0] cycle_addr, address_bus, service_addr;
  int          n_mismatch, tests_run, n, int_cnt;

  cbi_bus_seq dut (.*);
  cbi_mem_model peer (.*);

  // clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // acceptance count and acknowledge watch
  always @(posedge clock) begin
    if (int_taken) int_cnt++;
    if (!io_request_n) saw_io = 1'b1;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wait_hi(ref logic s);
    for (int k = 0; k < 80 && s !== 1'b1; k++) tick(1);
  endtask
  task complete_run;
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog
  initial begin
    #40000;
    n_mismatch++;
    complete_run;
  end
  // main sequence
  initial begin
    {srst, cycle_start, instr_done, stall, raise_irq, saw_io, clash} = 7'h40;
    {enable_irq_instr, disable_irq_instr, return_from_nonmaskable} = 3'h0;
    {return_from_maskable, load_acc_from_page_reg, load_acc_from_refresh_ctr} = 3'h0;
    {nmi_req_n, extra_states, cycle_addr, write_data} = 27'h4000000;
    cycle_kind = KIND_FETCH;
    n_mismatch = 0;
    tests_run = 0;
    int_cnt = 0;
    page_reg = 8'h12;
    tick(6);
    srst = 1'b0;
    chk({irq_enable_live, irq_enable_saved, cycle_busy, memory_request_n}, 16'h1);
    for (int i = 0; i < 8; i++) begin
      cycle_kind = rows[i].kind;
      extra_states = rows[i].extra;
      cycle_addr = {8'(i + 1), 8'h3C};
      write_data = 8'hA0 + 8'(i);
      stall = (i == 7);
      {saw_refresh_strobe_n, got} = 2'h0;
      // slow memory: let the filtered wait pin settle first
      if (i == 7) tick(4);
      pulse(cycle_start);
      for (n = 0; n < 40 && cycle_done !== 1'b1; n++) begin
        tick(1);
        if (!refresh_strobe_n) {saw_refresh_strobe_n, rf} = {1'b1, address_bus[6:0]};
        clash |= !refresh_strobe_n && !read_n;
        got |= read_valid;
      end
      chk(16'(got), 16'(rows[i].kind != KIND_WRITE));
      if (i == 7) chk(16'(n > 7 && n < 40), 16'h1);
      else chk(16'(n), 16'(rows[i].clks));
      if (rows[i].kind == KIND_FETCH) chk(16'(saw_refresh_strobe_n), 16'h1);
      if (i == 1 || i == 2) chk(16'(rf), 16'(prev_rf + 7'h1));
      prev_rf = rf;
      if (rows[i].kind == KIND_WRITE) chk(16'(last_write), 16'(write_data));
      else chk(16'(read_data), 16'(cycle_addr[7:0] + cycle_addr[15:8]));
    end
    chk(16'(clash), 16'h0);
    stall = 1'b0;
    pulse(enable_irq_instr);
    chk({irq_enable_live, irq_enable_saved}, 16'h3);
    pulse(load_acc_from_page_reg);
    chk(16'(parity_flag), 16'h1);
    nmi_req_n = 1'b0;
    tick(8);
    pulse(instr_done);
    wait_hi(nmi_taken);
    chk(service_addr, NMI_RESTART_ADDR);
    tick(1);
    chk({irq_enable_live, irq_enable_saved}, 16'h1);
    nmi_req_n = 1'b1;
    pulse(return_from_maskable);
    chk({irq_enable_live, irq_enable_saved}, 16'h1);
    pulse(return_from_nonmaskable);
    chk({irq_enable_live, irq_enable_saved}, 16'h3);
    pulse(disable_irq_instr);
    chk({irq_enable_live, irq_enable_saved}, 16'h0);
    pulse(load_acc_from_refresh_ctr);
    chk(16'(parity_flag), 16'h0);
    pulse(raise_irq);
    tick(8);
    pulse(instr_done);
    tick(8);
    chk(16'(int_cnt), 16'h0);
    pulse(enable_irq_instr);
    pulse(instr_done);
    tick(8);
    chk(16'(int_cnt), 16'h0);
    pulse(instr_done);
    wait_hi(int_taken);
    tick(1);
    chk({irq_enable_live, irq_enable_saved}, 16'h0);
    wait_hi(service_load);
    chk(service_addr, 16'h5352);
    chk(16'(saw_io), 16'h1);
    complete_run;
  end
endmodule
